// *** logic/fpra_defines.svh ***
`ifndef FPRA_DEFINES_SVH
`define FPRA_DEFINES_SVH

// Opcodes and confirmation byte.
`define FPRA_OP_ULTRA_PD 8'h79
`define FPRA_OP_LIGHT_PD 8'hb9
`define FPRA_OP_WAKE 8'hab
`define FPRA_OP_RST_EN 8'h66
`define FPRA_OP_RST 8'h99
`define FPRA_OP_ABORT 8'hf0
`define FPRA_CONFIRM 8'hd0
`define FPRA_OP_NONE 8'h00

// Bit counting.
`define FPRA_BYTE_BITS 3'h7
`define FPRA_CNT_ZERO 3'h0
`define FPRA_BYTES_ZERO 2'h0
`define FPRA_BYTES_ONE 2'h1
`define FPRA_BYTES_TWO 2'h2
`define FPRA_BYTES_MAX 2'h3

// Time limits in ns and the derived cycle counts at 125 MHz.
`define FPRA_CLK_NS 8
`define FPRA_ULTRA_ENTRY_NS 3000
`define FPRA_SW_RESET_NS 2000
`define FPRA_ABORT_START_NS 2000
`define FPRA_ULTRA_WAKE_NS 400
`define FPRA_CYC(ns) (16'((ns) / `FPRA_CLK_NS))
`define FPRA_ENTRY_CYC `FPRA_CYC(`FPRA_ULTRA_ENTRY_NS)
`define FPRA_RESET_CYC `FPRA_CYC(`FPRA_SW_RESET_NS)
`define FPRA_ABORT_CYC `FPRA_CYC(`FPRA_ABORT_START_NS)
`define FPRA_WAKE_CYC `FPRA_CYC(`FPRA_ULTRA_WAKE_NS)
`define FPRA_TIMER_ZERO 16'h0000
`define FPRA_TIMER_ONE 16'h0001

// Host link clock divider: half period in clock cycles, less one.
`define FPRA_SCK_HALF 4'h4
`define FPRA_DIV_ZERO 4'h0
`define FPRA_DIV_ONE 4'h1

// Host register map (word index on the software port).
`define FPRA_REG_CMD 2'h0
`define FPRA_REG_STATUS 2'h1
`define FPRA_REG_CTRL 2'h2
`define FPRA_CMD_BIT_TWO 16
`define FPRA_CMD_BIT_TRUNC 17
`define FPRA_LEN_ONE 5'h08
`define FPRA_LEN_TWO 5'h10

`endif

// *** logic/fpra_device.sv ***
// Notes on behaviour
// - Ultra power on 79h, or b9h with depth bit clear
// - In ultra power, only wake opcode is heard
// - Wake runs initialization then returns to standby
// - 79h is command only, no address or data
// - Each byte is eight clocks, MSB first
// - Extra bits ignored; enter on chip select rise
// - Off-byte chip select rise cancels ultra entry
// - 79h ignored while program or erase busy
// - Reset is 66h frame then 99h frame
// - Host lifts chip select between the two
// - Reset stops all work, restores defaults
// - Reset starts on chip select rise, blocks commands
// - Off-byte chip select rise cancels reset
// - Host checks busy and suspended before reset
// - Abort stops operation; it cannot be resumed
// - Abort ignores the write latch flag
// - Abort needs the abort permit bit set
// - Abort needs confirmation d0h or is dropped
// - Abort starts on chip select rise, blocks commands
// - Abort keeps volatile configuration registers
// - Aborted page contents are not guaranteed
// - Off-byte chip select rise drops abort
// - Wake does internal reset, loses volatile state
`timescale 1ns/1ns
`include "fpra_defines.svh"
module fpra_device
	import fpra_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Link from the host.
	fpra_link_if.device link,
	// Status from the array engine and configuration.
	input wire logic busy_flag,
	input wire logic write_latch_flag,
	input wire logic power_down_depth_select,
	input wire logic abort_permit_bit,
	// Device state outputs.
	output logic ultra_low_power_state,
	output logic light_power_down_state,
	output logic ready,
	output logic stop_operation,
	output logic clear_volatile
);
	fpra_dev_state_t state_q;
	logic [2:0] cs_sync_q;
	logic [2:0] sck_sync_q;
	logic [1:0] si_sync_q;
	logic [7:0] shift_q;
	logic [2:0] cnt_q;
	logic [1:0] bytes_q;
	logic [7:0] op_q;
	logic [7:0] second_q;
	logic rst_armed_q;
	logic [15:0] timer_q;
	logic ulp_q;
	logic lpd_q;
	logic ready_q;
	logic stop_q;
	logic clear_q;
	logic sck_rise;
	logic cs_rise;
	logic cs_active;
	logic [7:0] byte_in;
	logic aligned;

	// The first stage of each chain feeds only the second stage.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cs_sync_q <= 3'h7;
			sck_sync_q <= 3'h0;
			si_sync_q <= 2'h0;
		end else begin
			cs_sync_q <= {cs_sync_q[1:0], link.cs_n};
			sck_sync_q <= {sck_sync_q[1:0], link.sck};
			si_sync_q <= {si_sync_q[0], link.si};
		end
	end

	assign cs_active = !cs_sync_q[1];
	assign cs_rise = cs_sync_q[1] && !cs_sync_q[2];
	assign sck_rise = sck_sync_q[1] && !sck_sync_q[2] && cs_active;
	assign byte_in = {shift_q[6:0], si_sync_q[1]};
	assign aligned = cnt_q == `FPRA_CNT_ZERO;

	// Shift in MSB first; keep the first two bytes of the frame.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			shift_q <= 8'h00;
			cnt_q <= `FPRA_CNT_ZERO;
			bytes_q <= `FPRA_BYTES_ZERO;
			op_q <= `FPRA_OP_NONE;
			second_q <= `FPRA_OP_NONE;
		end else if (cs_rise || state_q != FPRA_STANDBY && !cs_active) begin
			cnt_q <= `FPRA_CNT_ZERO;
			bytes_q <= `FPRA_BYTES_ZERO;
		end else if (sck_rise) begin
			shift_q <= byte_in;
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == `FPRA_BYTE_BITS && bytes_q != `FPRA_BYTES_MAX) begin
				bytes_q <= bytes_q + 2'h1;
				if (bytes_q == `FPRA_BYTES_ZERO)
					op_q <= byte_in;
				else if (bytes_q == `FPRA_BYTES_ONE)
					second_q <= byte_in;
			end
		end else if (cs_active && bytes_q == `FPRA_BYTES_ZERO) begin
			op_q <= `FPRA_OP_NONE;
		end
	end

	// Reset enable is held only across the very next frame.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rst_armed_q <= 1'b0;
		end else if (cs_rise && state_q == FPRA_STANDBY) begin
			rst_armed_q <= aligned && bytes_q == `FPRA_BYTES_ONE &&
				op_q == `FPRA_OP_RST_EN;
		end else if (state_q != FPRA_STANDBY) begin
			rst_armed_q <= 1'b0;
		end
	end

	// Operating state and timers.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= FPRA_STANDBY;
			timer_q <= `FPRA_TIMER_ZERO;
			ulp_q <= 1'b0;
			lpd_q <= 1'b0;
			ready_q <= 1'b1;
			stop_q <= 1'b0;
			clear_q <= 1'b0;
		end else begin
			stop_q <= 1'b0;
			clear_q <= 1'b0;
			case (state_q)
			FPRA_STANDBY: begin
				if (cs_rise && aligned) begin
					// Whole bytes after a 79h opcode are ignored.
					if (bytes_q != `FPRA_BYTES_ZERO &&
						!busy_flag &&
						(op_q == `FPRA_OP_ULTRA_PD ||
						op_q == `FPRA_OP_LIGHT_PD &&
						!power_down_depth_select)) begin
						state_q <= FPRA_ULTRA;
						ulp_q <= 1'b1;
						ready_q <= 1'b0;
					end else if (op_q == `FPRA_OP_LIGHT_PD &&
						bytes_q == `FPRA_BYTES_ONE && !busy_flag) begin
						lpd_q <= 1'b1;
					end else if (rst_armed_q && op_q == `FPRA_OP_RST &&
						bytes_q == `FPRA_BYTES_ONE) begin
						state_q <= FPRA_RESETTING;
						timer_q <= `FPRA_RESET_CYC;
						ready_q <= 1'b0;
						stop_q <= 1'b1;
						clear_q <= 1'b1;
						lpd_q <= 1'b0;
					end else if (op_q == `FPRA_OP_ABORT &&
						bytes_q == `FPRA_BYTES_TWO &&
						second_q == `FPRA_CONFIRM &&
						abort_permit_bit) begin
						// Volatile configuration is left as it is.
						state_q <= FPRA_ABORTING;
						timer_q <= `FPRA_ABORT_CYC;
						ready_q <= 1'b0;
						stop_q <= 1'b1;
					end else if (op_q == `FPRA_OP_WAKE &&
						bytes_q == `FPRA_BYTES_ONE) begin
						lpd_q <= 1'b0;
					end
				end
			end
			FPRA_ULTRA: begin
				// Only a whole one-byte wake frame is heard here.
				if (cs_rise && aligned && bytes_q == `FPRA_BYTES_ONE &&
					op_q == `FPRA_OP_WAKE) begin
					state_q <= FPRA_WAKING;
					timer_q <= `FPRA_WAKE_CYC;
					clear_q <= 1'b1;
				end
			end
			FPRA_WAKING, FPRA_RESETTING, FPRA_ABORTING: begin
				timer_q <= timer_q - `FPRA_TIMER_ONE;
				if (timer_q == `FPRA_TIMER_ONE) begin
					state_q <= FPRA_STANDBY;
					ulp_q <= 1'b0;
					ready_q <= 1'b1;
				end
			end
			default: state_q <= FPRA_STANDBY;
			endcase
		end
	end

	assign ultra_low_power_state = ulp_q;
	assign light_power_down_state = lpd_q;
	assign ready = ready_q;
	assign stop_operation = stop_q;
	assign clear_volatile = clear_q;

	// Abort does not depend on the write latch, so it is not read.
	logic unused_latch;
	assign unused_latch = write_latch_flag;
endmodule // fpra_device

// *** logic/fpra_host.sv ***
`timescale 1ns/1ns
`include "fpra_defines.svh"
module fpra_host
	import fpra_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Link to the flash.
	fpra_link_if.host link,
	// Software port.
	input wire logic [1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata
);
	fpra_host_state_t state_q;
	logic [15:0] shift_q;
	logic [4:0] bits_q;
	logic [3:0] div_q;
	logic cs_n_q;
	logic sck_q;
	logic si_q;
	logic [15:0] cmd_q;
	logic [4:0] len_q;
	logic done_q;
	logic [31:0] rdata_q;
	logic go;

	assign link.cs_n = cs_n_q;
	assign link.sck = sck_q;
	assign link.si = si_q;
	assign rdata = rdata_q;
	assign go = wr && addr == `FPRA_REG_CMD && state_q == FPRA_H_IDLE;

	// Frame word: the first byte sits in the top half, so it leaves first.
	function automatic logic [15:0] frame_word(input logic [31:0] w);
		return {w[7:0], w[15:8]};
	endfunction

	// Bits in a frame: one or two bytes, less one for off-byte tests.
	function automatic logic [4:0] frame_bits(input logic [31:0] w);
		logic [4:0] full;
		full = w[`FPRA_CMD_BIT_TWO] ? `FPRA_LEN_TWO : `FPRA_LEN_ONE;
		return full - 5'(w[`FPRA_CMD_BIT_TRUNC]);
	endfunction

	// Write data: bits 7:0 first byte, 15:8 second byte sent after it.
	// Bit 16 selects two bytes; bit 17 drops the last bit of the frame.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cmd_q <= 16'h0000;
			len_q <= 5'h00;
		end else if (go) begin
			cmd_q <= frame_word(wdata);
			len_q <= frame_bits(wdata);
		end
	end

	// Link sequencer, one byte or two per frame, MSB first.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= FPRA_H_IDLE;
			cs_n_q <= 1'b1;
			sck_q <= 1'b0;
			si_q <= 1'b0;
			shift_q <= 16'h0000;
			bits_q <= 5'h00;
			div_q <= `FPRA_DIV_ZERO;
			done_q <= 1'b1;
		end else begin
			case (state_q)
			FPRA_H_IDLE: begin
				if (go) begin
					shift_q <= frame_word(wdata);
					bits_q <= frame_bits(wdata);
					cs_n_q <= 1'b0;
					si_q <= wdata[7];
					done_q <= 1'b0;
					div_q <= `FPRA_DIV_ZERO;
					state_q <= FPRA_H_LOW;
				end
			end
			FPRA_H_LOW: begin
				div_q <= div_q + `FPRA_DIV_ONE;
				if (div_q == `FPRA_SCK_HALF) begin
					div_q <= `FPRA_DIV_ZERO;
					sck_q <= 1'b1;
					shift_q <= {shift_q[14:0], 1'b0};
					bits_q <= bits_q - 5'h01;
					state_q <= FPRA_H_HIGH;
				end
			end
			FPRA_H_HIGH: begin
				div_q <= div_q + `FPRA_DIV_ONE;
				if (div_q == `FPRA_SCK_HALF) begin
					div_q <= `FPRA_DIV_ZERO;
					sck_q <= 1'b0;
					si_q <= shift_q[15];
					if (bits_q == 5'h00) begin
						cs_n_q <= 1'b1;
						state_q <= FPRA_H_GAP;
					end else begin
						state_q <= FPRA_H_LOW;
					end
				end
			end
			FPRA_H_GAP: begin
				// Chip select stays high a full half period before reuse.
				div_q <= div_q + `FPRA_DIV_ONE;
				if (div_q == `FPRA_SCK_HALF) begin
					div_q <= `FPRA_DIV_ZERO;
					done_q <= 1'b1;
					state_q <= FPRA_H_IDLE;
				end
			end
			default: state_q <= FPRA_H_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rdata_q <= 32'h00000000;
		end else if (rd) begin
			case (addr)
			`FPRA_REG_CMD: rdata_q <= {11'h000, len_q, cmd_q};
			`FPRA_REG_STATUS: rdata_q <= {31'h00000000, done_q};
			default: rdata_q <= 32'h00000000;
			endcase
		end
	end
endmodule // fpra_host

// *** logic/fpra_link_if.sv ***
`timescale 1ns/1ns
interface fpra_link_if;
	logic cs_n;
	logic sck;
	logic si;
	modport device (
		input cs_n,
		input sck,
		input si
	);
	modport host (
		output cs_n,
		output sck,
		output si
	);
endinterface

// *** logic/fpra_pkg.sv ***
package fpra_pkg;
	// Device operating states, one-hot.
	typedef enum logic [4:0] {
		FPRA_STANDBY = 5'h01,
		FPRA_ULTRA = 5'h02,
		FPRA_WAKING = 5'h04,
		FPRA_RESETTING = 5'h08,
		FPRA_ABORTING = 5'h10
	} fpra_dev_state_t;

	// Host sequencer states, one-hot.
	typedef enum logic [3:0] {
		FPRA_H_IDLE = 4'h1,
		FPRA_H_LOW = 4'h2,
		FPRA_H_HIGH = 4'h4,
		FPRA_H_GAP = 4'h8
	} fpra_host_state_t;
endpackage

// *** verif/fpra_link_checker.sv ***
`timescale 1ns/1ns
module fpra_link_checker (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Link.
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si
);
	logic sck_q;
	logic [4:0] bits_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= sck;
		end
	end
	// Counts serial clock rises within the current frame.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			bits_q <= 5'h0;
		end else if (cs_n) begin
			bits_q <= 5'h0;
		end else if (sck && !sck_q) begin
			bits_q <= bits_q + 5'h1;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	idle_clock_a: assert property (cs_n |-> !sck)
		else $error("clock high while deselected");
	whole_byte_a: assert property ($rose(cs_n) |-> bits_q != 5'h0 &&
		(bits_q[2:0] == 3'h0 || bits_q[2:0] == 3'h7))
		else $error("frame neither whole nor one short");
	data_stable_a: assert property (sck && sck_q |-> $stable(si))
		else $error("data moved while clock high");
	select_gap_a: assert property ($rose(cs_n) |=> cs_n [*3])
		else $error("select gap too short");
	frame_start_a: assert property ($fell(cs_n) |-> !sck)
		else $error("select fell with clock high");
	first_clock_a: assert property ($fell(cs_n) |-> ##[1:20] $rose(sck))
		else $error("no clock after select");
	high_phase_a: assert property ($rose(sck) |-> sck [*3])
		else $error("clock high phase short");
	frame_end_a: assert property ($rose(cs_n) |-> $fell(sck))
		else $error("select rose with clock high");
	frame_len_a: assert property (!cs_n |-> bits_q <= 5'h10)
		else $error("frame longer than two bytes");
endmodule // fpra_link_checker

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
	logic clock, reset, wr, rd, busy, latch, depth, permit;
	logic ultra, light, ready, stop_op, clr_vol;
	logic [1:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] cap;
	int num_errors, checks_done, cycles, n_stop, n_clr, s, c;
	fpra_link_if link();
	fpra_host i_fpra_host(.clock(clock), .reset(reset), .link(link),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	fpra_device i_fpra_device(.clock(clock), .reset(reset), .link(link),
		.busy_flag(busy), .write_latch_flag(latch),
		.power_down_depth_select(depth), .abort_permit_bit(permit),
		.ultra_low_power_state(ultra), .light_power_down_state(light),
		.ready(ready), .stop_operation(stop_op), .clear_volatile(clr_vol));
	fpra_link_checker i_fpra_link_checker(.clock(clock), .reset(reset),
		.cs_n(link.cs_n), .sck(link.sck), .si(link.si));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// Shifts in what the device sees on each serial clock rise.
	always @(posedge link.sck) begin
		if (link.cs_n === 1'b0) cap <= {cap[14:0], link.si};
	end
	always @(negedge link.cs_n) cap <= 16'h0;
	always @(negedge clock) begin
		n_stop += (stop_op === 1'b1);
		n_clr += (clr_vol === 1'b1);
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			complete_run;
		end
	end
	task check(input string w, input logic [15:0] seen, input logic [15:0] e);
		checks_done++;
		if (seen !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", w, e, seen);
		end
	endtask
	// Bits 7:0 first byte, 15:8 second, 16 two bytes, 17 one bit short.
	// One read strobe; the word is taken in the cycle after it.
	task read_reg(input logic [1:0] a, output logic [31:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(posedge clock);
		d = rdata;
	endtask
	task send(input logic [17:0] v);
		logic [15:0] e;
		logic [15:0] n;
		logic [31:0] word;
		e = v[16] ? {v[7:0], v[15:8]} : {8'h0, v[7:0]};
		n = v[16] ? 16'h10 : 16'h08;
		n = n - 16'(v[17]);
		@(posedge clock);
		wr <= 1'b1;
		addr <= 2'h0;
		wdata <= {14'h0, v};
		@(posedge clock);
		wr <= 1'b0;
		word = 32'h0;
		while (word[0] !== 1'b1) read_reg(2'h1, word);
		read_reg(2'h0, word);
		check("cmd", word[15:0], {v[7:0], v[15:8]});
		check("len", 16'(word[20:16]), n);
		if (!v[17]) check("frame", cap, e);
	endtask
	task settle;
		for (int n = 0; n < 600 && ready !== 1'b1; n++) @(posedge clock);
	endtask
	task t_ultra(input logic [17:0] v);
		c = n_clr;
		send(v);
		check("ultra", ultra, 1'b1);
		check("ready", ready, 1'b0);
		send(18'h00066);
		send(18'h00099);
		check("held", ultra, 1'b1);
		send(18'h000ab);
		settle;
		check("woke", ultra, 1'b0);
		check("wipe", 16'(n_clr - c), 16'h1);
		$display("ultra test done");
	endtask
	task t_refuse;
		busy <= 1'b1;
		send(18'h00079);
		check("busy", ultra, 1'b0);
		busy <= 1'b0;
		send(18'h20079);
		check("short", ultra, 1'b0);
		c = n_clr;
		send(18'h00066);
		send(18'h20099);
		send(18'h00066);
		send(18'h000ab);
		send(18'h00099);
		check("wipe", 16'(n_clr - c), 16'h0);
		s = n_stop;
		permit <= 1'b1;
		send(18'h3d0f0);
		check("stop", 16'(n_stop - s), 16'h0);
		check("ready", ready, 1'b1);
		$display("refusal test done");
	endtask
	task t_light;
		depth <= 1'b0;
		t_ultra(18'h000b9);
		depth <= 1'b1;
		send(18'h000b9);
		check("light", light, 1'b1);
		check("ultra", ultra, 1'b0);
		send(18'h000ab);
		settle;
		check("lit", light, 1'b0);
		$display("light test done");
	endtask
	task t_reset;
		busy <= 1'b0;
		check("idle", ready, 1'b1);
		s = n_stop;
		c = n_clr;
		send(18'h00066);
		send(18'h00099);
		check("ready", ready, 1'b0);
		check("stop", 16'(n_stop - s), 16'h1);
		check("wipe", 16'(n_clr - c), 16'h1);
		send(18'h00079);
		settle;
		check("ultra", ultra, 1'b0);
		$display("reset test done");
	endtask
	task t_abort;
		s = n_stop;
		c = n_clr;
		permit <= 1'b0;
		send(18'h1d0f0);
		check("stop", 16'(n_stop - s), 16'h0);
		permit <= 1'b1;
		send(18'h1c0f0);
		check("stop", 16'(n_stop - s), 16'h0);
		send(18'h1d0f0);
		check("stop", 16'(n_stop - s), 16'h1);
		check("ready", ready, 1'b0);
		send(18'h00079);
		settle;
		check("ultra", ultra, 1'b0);
		latch <= 1'b1;
		send(18'h1d0f0);
		settle;
		check("stop", 16'(n_stop - s), 16'h2);
		check("wipe", 16'(n_clr - c), 16'h0);
		$display("abort test done");
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		{wr, rd, busy, latch, permit, addr, wdata} = '0;
		depth = 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		t_ultra(18'h00079);
		t_ultra(18'h15579);
		t_refuse;
		t_light;
		t_reset;
		t_abort;
		complete_run;
	end
endmodule // tb_top
